/* shared/pmt_pkg.sv */
// pmt_pkg: register map, field layout, reset values and constants of the memory type lookup
package pmt_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned TYPE_W     = 3;
  localparam int unsigned NUM_VAR    = 8;
  localparam int unsigned NUM_FIX    = 88;
  localparam int unsigned FIX_IDX_W  = 7;
  localparam int unsigned TLB_N      = 8;
  localparam int unsigned PAGE_W     = 20;

  // ***************************************************************
  // memory types
  // ***************************************************************
  typedef enum logic [2:0] {
    PMT_UNCACHEABLE = 3'h0,
    PMT_WCOMB       = 3'h1,
    PMT_WTHRU       = 3'h4,
    PMT_WPROT       = 3'h5,
    PMT_WBACK       = 3'h6
  } pmt_type_t;

  // ***************************************************************
  // fixed region bands
  // ***************************************************************
  localparam logic [31:0] FIX_BAND0_END = 32'h0007ffff;
  localparam logic [31:0] FIX_BAND1_END = 32'h000bffff;
  localparam logic [31:0] FIX_BAND2_END = 32'h000fffff;
  localparam int unsigned BAND0_SHIFT   = 16;
  localparam int unsigned BAND1_SHIFT   = 14;
  localparam int unsigned BAND2_SHIFT   = 12;
  localparam logic [6:0]  BAND1_BASE_IX = 7'h08;
  localparam logic [6:0]  BAND2_BASE_IX = 7'h18;
  localparam logic [31:0] LOW_MEG_END   = 32'h000fffff;
  localparam logic [31:0] LARGE_PG_MASK = 32'hffc00000;

  // ***************************************************************
  // register offsets (byte addresses)
  // ***************************************************************
  localparam logic [11:0] OFS_CAP       = 12'h000;
  localparam logic [11:0] OFS_DEF_TYPE  = 12'h004;
  localparam logic [11:0] OFS_CACHE_CTL = 12'h008;
  localparam logic [11:0] OFS_PTBASE    = 12'h00c;
  localparam logic [11:0] OFS_EXT_CTL   = 12'h010;
  localparam logic [11:0] OFS_STATUS    = 12'h014;
  localparam logic [11:0] OFS_FIX_IDX   = 12'h018;
  localparam logic [11:0] OFS_FIX_DATA  = 12'h01c;
  localparam logic [11:0] OFS_VAR_BASE  = 12'h100;
  localparam logic [11:0] OFS_VAR_MASK  = 12'h104;
  localparam logic [11:0] VAR_STRIDE    = 12'h008;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int unsigned CAP_VAR_CNT_LSB = 0;
  localparam int unsigned CAP_FIX_BIT     = 8;
  localparam int unsigned DEF_E_BIT       = 11;
  localparam int unsigned DEF_FIX_EN_BIT  = 10;
  localparam int unsigned CACHE_DIS_BIT   = 30;
  localparam int unsigned NOT_WTHRU_BIT   = 29;
  localparam int unsigned GPAGE_EN_BIT    = 7;
  localparam int unsigned MASK_V_BIT      = 11;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [31:0] DEF_TYPE_RST  = 32'h00000000;
  localparam logic [31:0] CACHE_CTL_RST = 32'h60000000;
  localparam logic [31:0] EXT_CTL_RST   = 32'h00000000;
  localparam logic [31:0] PTBASE_RST    = 32'h00000000;
  localparam logic [7:0]  VAR_CNT_VALUE = 8'h08;

endpackage : pmt_pkg

/* verilog/pmt_fix_mem.sv */
// pmt_fix_mem: fixed-range type store with registered read port
`timescale 1ns/100ps
module pmt_fix_mem
  import pmt_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 wr_en,
  input  wire logic [FIX_IDX_W-1:0] wr_idx,
  input  wire logic [TYPE_W-1:0]    wr_data,
  input  wire logic [FIX_IDX_W-1:0] rd_idx,
  output logic      [TYPE_W-1:0]    rd_data
);

  logic [TYPE_W-1:0] mem_q [NUM_FIX];
  logic [TYPE_W-1:0] rd_data_d;

  always_comb begin
    rd_data_d = (32'(rd_idx) < NUM_FIX) ? mem_q[rd_idx] : PMT_UNCACHEABLE;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_data <= PMT_UNCACHEABLE;
    end else begin
      rd_data <= rd_data_d;
    end
    if (wr_en && 32'(wr_idx) < NUM_FIX) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

endmodule : pmt_fix_mem

/* verilog/pmt_lookup.sv */
// pmt_lookup: physical address memory type resolution with APB registers and type TLB
`timescale 1ns/100ps
module pmt_lookup
  import pmt_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  input  wire logic              lkp_req,
  input  wire logic [ADDR_W-1:0] lkp_addr,
  input  wire logic              lkp_large,
  output logic                   lkp_valid,
  output logic      [TYPE_W-1:0] lkp_type,
  output logic                   lkp_split,
  output logic                   lkp_hit,
  output logic                   cache_no_fill,
  output logic                   tlb_flush
);

  // ***************************************************************
  // functions
  // ***************************************************************
  function automatic logic [FIX_IDX_W-1:0] fix_index(input logic [ADDR_W-1:0] a);
    logic [31:0] ix;
    ix = 32'h0;
    if (a <= FIX_BAND0_END) begin
      ix = a >> BAND0_SHIFT;
    end else if (a <= FIX_BAND1_END) begin
      ix = 32'(BAND1_BASE_IX) + ((a - 32'h00080000) >> BAND1_SHIFT);
    end else begin
      ix = 32'(BAND2_BASE_IX) + ((a - 32'h000c0000) >> BAND2_SHIFT);
    end
    return ix[FIX_IDX_W-1:0];
  endfunction : fix_index

  function automatic logic var_match(input logic [ADDR_W-1:0] a, input logic [31:0] b,
                                     input logic [31:0] m);
    logic [31:0] mk;
    mk = {m[31:12], 12'h000};
    return m[MASK_V_BIT] && ((a & mk) == (b & mk));
  endfunction : var_match

  // ***************************************************************
  // registers
  // ***************************************************************
  typedef enum logic [1:0] {PMT_IDLE, PMT_FIX_RD, PMT_DONE} pmt_state_t;

  pmt_state_t        state_q, state_d;
  logic [31:0]       def_q, def_d, cc_q, cc_d, ext_q, ext_d, ptb_q, ptb_d;
  logic [6:0]        fidx_q, fidx_d;
  logic [31:0]       vbase_q [NUM_VAR];
  logic [31:0]       vmask_q [NUM_VAR];
  logic [31:0]       vbase_d [NUM_VAR];
  logic [31:0]       vmask_d [NUM_VAR];
  logic              pready_d, pslverr_d, flush_d, lv_d, split_d, hit_d;
  logic [31:0]       prdata_d;
  logic [TYPE_W-1:0] ltype_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              large_q, large_d;
  logic [PAGE_W-1:0] tlb_tag_q [TLB_N];
  logic [TYPE_W-1:0] tlb_typ_q [TLB_N];
  logic [TLB_N-1:0]  tlb_v_q, tlb_v_d;
  logic [PAGE_W-1:0] tlb_tag_d [TLB_N];
  logic [TYPE_W-1:0] tlb_typ_d [TLB_N];
  logic [2:0]        tlb_ptr_q, tlb_ptr_d;
  logic [TYPE_W-1:0] fix_rd;
  logic              fix_we;
  logic [TYPE_W-1:0] var_type, low_type, res_type;
  logic              var_hit, fix_sel, apb_wr, fix_in_low;
  logic [3:0]        vi;
  logic [2:0]        hit_ix;
  logic              tlb_any;

  assign apb_wr = psel && penable && pwrite && pready;
  assign fix_we = apb_wr && paddr == OFS_FIX_DATA;

  pmt_fix_mem u_fix (
    .core_clk (core_clk),
    .reset    (reset),
    .wr_en    (fix_we),
    .wr_idx   (fidx_q),
    .wr_data  (pwdata[TYPE_W-1:0]),
    .rd_idx   ((state_q == PMT_IDLE) ? fix_index(lkp_addr) : fix_index(addr_q)),
    .rd_data  (fix_rd)
  );

  // ***************************************************************
  // variable range scan and resolution
  // ***************************************************************
  always_comb begin
    var_hit  = 1'b0;
    var_type = def_q[TYPE_W-1:0];
    for (int i = NUM_VAR - 1; i >= 0; i--) begin
      if (8'(i) < VAR_CNT_VALUE && var_match(addr_q, vbase_q[i], vmask_q[i])) begin
        var_hit  = 1'b1;
        var_type = vbase_q[i][TYPE_W-1:0];
      end
    end
    fix_sel  = def_q[DEF_FIX_EN_BIT] && (addr_q <= FIX_BAND2_END);
    fix_in_low = (addr_q & LARGE_PG_MASK) == 32'h0;
    low_type = var_hit ? var_type : def_q[TYPE_W-1:0];
    if (!def_q[DEF_E_BIT]) begin
      res_type = PMT_UNCACHEABLE;
    end else if (fix_sel) begin
      res_type = fix_rd;
    end else begin
      res_type = low_type;
    end
  end

  // ***************************************************************
  // tlb hit check
  // ***************************************************************
  always_comb begin
    tlb_any = 1'b0;
    hit_ix  = 3'h0;
    for (int i = 0; i < TLB_N; i++) begin
      if (tlb_v_q[i] && tlb_tag_q[i] == lkp_addr[ADDR_W-1:12]) begin
        tlb_any = 1'b1;
        hit_ix  = 3'(i);
      end
    end
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    state_d   = state_q;
    def_d     = def_q;
    cc_d      = cc_q;
    ext_d     = ext_q;
    ptb_d     = ptb_q;
    fidx_d    = fidx_q;
    vbase_d   = vbase_q;
    vmask_d   = vmask_q;
    addr_d    = addr_q;
    large_d   = large_q;
    tlb_v_d   = tlb_v_q;
    tlb_tag_d = tlb_tag_q;
    tlb_typ_d = tlb_typ_q;
    tlb_ptr_d = tlb_ptr_q;
    flush_d   = 1'b0;
    lv_d      = 1'b0;
    ltype_d   = lkp_type;
    split_d   = lkp_split;
    hit_d     = lkp_hit;
    pready_d  = psel && !penable;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0;
    vi        = 4'h0;
    // apb access phase lands on the cycle after setup
    if (psel && !penable) begin
      if (!pwrite) begin
        if (paddr == OFS_CAP) begin
          prdata_d = {23'h0, 1'b1, VAR_CNT_VALUE};
        end else if (paddr == OFS_DEF_TYPE) begin
          prdata_d = def_q;
        end else if (paddr == OFS_CACHE_CTL) begin
          prdata_d = cc_q;
        end else if (paddr == OFS_PTBASE) begin
          prdata_d = ptb_q;
        end else if (paddr == OFS_EXT_CTL) begin
          prdata_d = ext_q;
        end else if (paddr == OFS_STATUS) begin
          prdata_d = {28'h0, cache_no_fill, state_q != PMT_IDLE, |tlb_v_q, def_q[DEF_E_BIT]};
        end else if (paddr == OFS_FIX_IDX) begin
          prdata_d = {25'h0, fidx_q};
        end else if (paddr >= OFS_VAR_BASE && paddr < OFS_VAR_BASE + 12'h040) begin
          vi = 4'((paddr - OFS_VAR_BASE) >> 3);
          prdata_d = paddr[2] ? vmask_q[vi[2:0]] : vbase_q[vi[2:0]];
        end else begin
          pslverr_d = 1'b1;
        end
      end else begin
        pslverr_d = !(paddr <= OFS_FIX_DATA && paddr != OFS_CAP && paddr != OFS_STATUS)
                    && !(paddr >= OFS_VAR_BASE && paddr < OFS_VAR_BASE + 12'h040);
      end
      if (paddr[1:0] != 2'h0) begin
        pslverr_d = 1'b1;
      end
    end
    if (apb_wr && !pslverr) begin
      if (paddr == OFS_DEF_TYPE) begin
        def_d = pwdata & 32'h00000c07;
      end else if (paddr == OFS_CACHE_CTL) begin
        cc_d = pwdata;
      end else if (paddr == OFS_PTBASE) begin
        ptb_d   = pwdata;
        flush_d = 1'b1;
      end else if (paddr == OFS_EXT_CTL) begin
        ext_d = pwdata;
        if (ext_q[GPAGE_EN_BIT] && !pwdata[GPAGE_EN_BIT]) begin
          flush_d = 1'b1;
        end
      end else if (paddr == OFS_FIX_IDX) begin
        fidx_d = pwdata[6:0];
      end else if (paddr >= OFS_VAR_BASE) begin
        vi = 4'((paddr - OFS_VAR_BASE) >> 3);
        if (paddr[2]) begin
          vmask_d[vi[2:0]] = pwdata & 32'hfffff800;
        end else begin
          vbase_d[vi[2:0]] = pwdata & 32'hfffff007;
        end
      end
    end
    // lookup pipeline
    case (state_q)
      PMT_IDLE: begin
        if (lkp_req) begin
          addr_d  = lkp_addr;
          large_d = lkp_large;
          state_d = PMT_FIX_RD;
        end
      end
      PMT_FIX_RD: begin
        state_d = PMT_DONE;
      end
      PMT_DONE: begin
        // default and variable range registers are read live here; the fixed type comes from the u_fix read register loaded in PMT_FIX_RD
        lv_d    = 1'b1;
        ltype_d = res_type;
        hit_d   = 1'b0;
        // large page touching the low meg with a differing fixed type splits
        split_d = large_q && fix_in_low && fix_sel && (fix_rd != low_type);
        if (!large_q || split_d) begin
          tlb_tag_d[tlb_ptr_q] = addr_q[ADDR_W-1:12];
          tlb_typ_d[tlb_ptr_q] = res_type;
          tlb_v_d[tlb_ptr_q]   = 1'b1;
          tlb_ptr_d            = tlb_ptr_q + 3'h1;
        end
        state_d = PMT_IDLE;
      end
      default: state_d = PMT_IDLE;
    endcase
    // a cached page answers at once; typing changes require software flush
    if (state_q == PMT_IDLE && lkp_req && tlb_any && def_q[DEF_E_BIT] && !flush_d) begin
      lv_d    = 1'b1;
      ltype_d = tlb_typ_q[hit_ix];
      hit_d   = 1'b1;
      split_d = 1'b0;
      state_d = PMT_IDLE;
    end
    if (flush_d) begin
      tlb_v_d = '0;
    end
  end

  // ***************************************************************
  // state registers
  // ***************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q       <= PMT_IDLE;
      def_q         <= DEF_TYPE_RST;
      cc_q          <= CACHE_CTL_RST;
      ext_q         <= EXT_CTL_RST;
      ptb_q         <= PTBASE_RST;
      fidx_q        <= 7'h0;
      addr_q        <= 32'h0;
      large_q       <= 1'b0;
      tlb_v_q       <= '0;
      tlb_ptr_q     <= 3'h0;
      pready        <= 1'b0;
      prdata        <= 32'h0;
      pslverr       <= 1'b0;
      lkp_valid     <= 1'b0;
      lkp_type      <= PMT_UNCACHEABLE;
      lkp_split     <= 1'b0;
      lkp_hit       <= 1'b0;
      tlb_flush     <= 1'b0;
      cache_no_fill <= 1'b1;
      for (int i = 0; i < NUM_VAR; i++) begin
        vbase_q[i] <= 32'h0;
        vmask_q[i] <= 32'h0;
      end
      for (int i = 0; i < TLB_N; i++) begin
        tlb_tag_q[i] <= '0;
        tlb_typ_q[i] <= PMT_UNCACHEABLE;
      end
    end else begin
      state_q       <= state_d;
      def_q         <= def_d;
      cc_q          <= cc_d;
      ext_q         <= ext_d;
      ptb_q         <= ptb_d;
      fidx_q        <= fidx_d;
      addr_q        <= addr_d;
      large_q       <= large_d;
      tlb_v_q       <= tlb_v_d;
      tlb_ptr_q     <= tlb_ptr_d;
      tlb_tag_q     <= tlb_tag_d;
      tlb_typ_q     <= tlb_typ_d;
      vbase_q       <= vbase_d;
      vmask_q       <= vmask_d;
      pready        <= pready_d;
      prdata        <= prdata_d;
      pslverr       <= pslverr_d;
      lkp_valid     <= lv_d;
      lkp_type      <= ltype_d;
      lkp_split     <= split_d;
      lkp_hit       <= hit_d;
      tlb_flush     <= flush_d;
      cache_no_fill <= cc_d[CACHE_DIS_BIT];
    end
  end

endmodule : pmt_lookup

/* tb/pmt_lookup_monitor.sv */
// pmt_lookup_monitor: port assertions for the memory type lookup
`timescale 1ns/100ps
module pmt_lookup_monitor
  import pmt_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              lkp_req,
  input wire logic [ADDR_W-1:0] lkp_addr,
  input wire logic              lkp_large,
  input wire logic              lkp_valid,
  input wire logic [TYPE_W-1:0] lkp_type,
  input wire logic              lkp_split,
  input wire logic              lkp_hit,
  input wire logic              cache_no_fill,
  input wire logic              tlb_flush
);
  // ***************************************************************
  // shadow of the enable flags
  // ***************************************************************
  logic wr_acc;
  logic ge_q, ge_d, gpe_q, gpe_d;
  assign wr_acc = psel && penable && pready && pwrite;
  always_comb begin
    ge_d  = ge_q;
    gpe_d = gpe_q;
    if (wr_acc && paddr == OFS_DEF_TYPE) ge_d = pwdata[DEF_E_BIT];
    if (wr_acc && paddr == OFS_EXT_CTL) gpe_d = pwdata[GPAGE_EN_BIT];
  end
  always_ff @(posedge core_clk) begin
    ge_q  <= reset ? 1'b0 : ge_d;
    gpe_q <= reset ? 1'b0 : gpe_d;
  end
  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_ready_single: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single access-cycle pulse");
  a_bad_addr_err: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  a_cap_ro_err: assert property (wr_acc && paddr == OFS_CAP |-> pslverr)
    else $error("capability write not refused");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_uc_when_off: assert property (lkp_valid && !ge_q |-> lkp_type == 3'h0)
    else $error("type not uncacheable while disabled");
  a_ptbase_flush: assert property (wr_acc && paddr == OFS_PTBASE |-> ##[1:2] tlb_flush)
    else $error("no flush after page base write");
  a_gpage_clr_flush: assert property (wr_acc && paddr == OFS_EXT_CTL && gpe_q
    && !pwdata[GPAGE_EN_BIT]
    |-> ##[1:2] tlb_flush)
    else $error("no flush after global page clear");
  a_flush_pulse: assert property (tlb_flush |=> !tlb_flush)
    else $error("flush longer than one cycle");
  a_no_fill_follow: assert property (wr_acc && paddr == OFS_CACHE_CTL
    |-> ##2 cache_no_fill == $past(pwdata[CACHE_DIS_BIT], 2))
    else $error("no-fill mode not following cache disable");
  a_miss_latency: assert property (lkp_valid && !lkp_hit |-> $past(lkp_req, 3))
    else $error("miss answer at wrong time");
endmodule : pmt_lookup_monitor

/* tb/pmt_lookup_tb.sv */
// pmt_lookup_tb: random and corner-case bench for the memory type lookup
`timescale 1ns/100ps
module pmt_lookup_tb import pmt_pkg::*;;
  logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, e;
  logic        lkp_req, lkp_large, lkp_valid, lkp_split, lkp_hit, cache_no_fill, tlb_flush;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, lkp_addr, a;
  logic [2:0]  lkp_type, dt, fixm[88];
  logic [31:0] vb[8], vm[8];
  logic [2:0]  tys[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
  logic        ge, fix_en;
  integer      seed = 32'h1d6bc2ef;
  int          fail_count, compares, cyc;

  pmt_lookup dut_u (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lkp_req(lkp_req), .lkp_addr(lkp_addr), .lkp_large(lkp_large),
    .lkp_valid(lkp_valid), .lkp_type(lkp_type), .lkp_split(lkp_split), .lkp_hit(lkp_hit),
    .cache_no_fill(cache_no_fill), .tlb_flush(tlb_flush));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ***************************************************************
  // tasks and expectation functions
  // ***************************************************************
  task report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task lk(input logic [31:0] ad, input logic l);
    @(posedge core_clk);
    lkp_req   <= 1'b1;
    lkp_addr  <= ad;
    lkp_large <= l;
    @(posedge core_clk);
    lkp_req   <= 1'b0;
    // a hang is caught by the cycle ceiling
    while (lkp_valid !== 1'b1) begin
      @(posedge core_clk);
    end
  endtask : lk
  function automatic int fix_ix(input logic [31:0] ad);
    if (ad <= FIX_BAND0_END) return int'(ad >> BAND0_SHIFT);
    if (ad <= FIX_BAND1_END) return 8 + int'((ad - 32'h80000) >> BAND1_SHIFT);
    return 24 + int'((ad - 32'hc0000) >> BAND2_SHIFT);
  endfunction : fix_ix
  function automatic logic [2:0] var_ty(input logic [31:0] ad);
    for (int i = 0; i < 8; i++)
      if (vm[i][MASK_V_BIT] && (ad & vm[i] & 32'hfffff000) == (vb[i] & vm[i] & 32'hfffff000))
        return vb[i][2:0];
    return dt;
  endfunction : var_ty
  function automatic logic [2:0] exp_ty(input logic [31:0] ad);
    if (!ge) return 3'h0;
    if (fix_en && ad <= FIX_BAND2_END) return fixm[fix_ix(ad)];
    return var_ty(ad);
  endfunction : exp_ty
  task ck(input logic [31:0] ad);
    lk(ad, 1'b0);
    chk(lkp_type, exp_ty(ad));
  endtask : ck
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    {reset, psel, penable, pwrite, lkp_req, lkp_large} = 6'h20;
    {paddr, pwdata, lkp_addr} = '0;
    {ge, fix_en, dt, fail_count, compares, cyc} = '0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    chk(cache_no_fill, 1'b1);
    apb(1'b0, OFS_CAP, 32'h0);
    chk(r, {23'h0, 1'b1, VAR_CNT_VALUE});
    apb(1'b1, OFS_CAP, 32'h0);
    chk(e, 1'b1);
    apb(1'b0, 12'h020, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, 12'h006, 32'h0);
    chk(e, 1'b1);
    $display("test registers done");
    for (int i = 0; i < 88; i++) begin
      fixm[i] = tys[$unsigned($random(seed)) % 5];
      apb(1'b1, OFS_FIX_IDX, i);
      apb(1'b1, OFS_FIX_DATA, {29'h0, fixm[i]});
    end
    for (int i = 0; i < 8; i++) begin
      vb[i] = ($random(seed) & 32'hfffff000) | tys[$unsigned($random(seed)) % 5];
      vm[i] = ($random(seed) | 32'hffc00000) & 32'hfffff000;
      vm[i][MASK_V_BIT] = (i != 3);
      apb(1'b1, 12'(OFS_VAR_BASE + VAR_STRIDE * i), vb[i]);
      apb(1'b1, 12'(OFS_VAR_MASK + VAR_STRIDE * i), vm[i]);
    end
    dt = tys[$unsigned($random(seed)) % 5];
    fix_en = 1'b1;
    apb(1'b1, OFS_DEF_TYPE, {20'h0, 1'b0, 1'b1, 7'h0, 3'(dt)});
    for (int k = 0; k < 8; k++) ck($random(seed) & (k[0] ? 32'hfffff : 32'hffffffff));
    ge = 1'b1;
    // ranges written while disabled; one requester, no interrupts; the OFS_PTBASE write flushes the TLB filled while disabled
    apb(1'b1, OFS_DEF_TYPE, {20'h0, 1'b1, 1'b1, 7'h0, 3'(dt)});
    apb(1'b1, OFS_PTBASE, 32'h0);
    foreach (tys[j]) begin
      ck(32'h7ffff + 32'h40000 * j);
      ck(32'h80000 + 32'h40000 * j);
    end
    for (int k = 0; k < 60; k++) begin
      a = $random(seed);
      if (k % 3 == 0) a = a & 32'hfffff;
      if (k % 3 == 1) a = (vb[k % 8] & 32'hfffff000) | (a & 32'hfff);
      ck(a);
    end
    $display("test type resolution done");
    lk(a, 1'b0);
    chk(lkp_hit, 1'b1);
    apb(1'b1, OFS_PTBASE, 32'h0);
    lk(a, 1'b0);
    chk(lkp_hit, 1'b0);
    apb(1'b1, OFS_EXT_CTL, 32'h80);
    ck(a);
    apb(1'b1, OFS_EXT_CTL, 32'h0);
    lk(a, 1'b0);
    chk(lkp_hit, 1'b0);
    fix_en = 1'b0;
    apb(1'b1, OFS_DEF_TYPE, {20'h0, 1'b1, 1'b0, 7'h0, 3'(dt)});
    apb(1'b1, OFS_PTBASE, 32'h0);
    for (int k = 0; k < 6; k++) ck($random(seed) & 32'hfffff);
    $display("test flush done");
    // force a fixed type at page zero that conflicts with the variable/default type
    apb(1'b1, OFS_DEF_TYPE, {20'h0, 1'b0, 1'b0, 7'h0, 3'(dt)});
    fixm[0] = (var_ty(32'h0) == 3'h6) ? 3'h0 : 3'h6;
    apb(1'b1, OFS_FIX_IDX, 32'h0);
    apb(1'b1, OFS_FIX_DATA, {29'h0, fixm[0]});
    fix_en = 1'b1;
    apb(1'b1, OFS_DEF_TYPE, {20'h0, 1'b1, 1'b1, 7'h0, 3'(dt)});
    apb(1'b1, OFS_PTBASE, 32'h0);
    lk(32'h0, 1'b1);
    chk(lkp_split, 1'b1);
    chk(lkp_type, exp_ty(32'h0));
    lk(32'h00800000, 1'b1);
    chk(lkp_split, 1'b0);
    apb(1'b1, OFS_CACHE_CTL, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(cache_no_fill, 1'b0);
    apb(1'b1, OFS_CACHE_CTL, 32'h40000000);
    repeat (2) @(posedge core_clk);
    chk(cache_no_fill, 1'b1);
    $display("test large page and cache mode done");
    report_and_stop();
  end
endmodule : pmt_lookup_tb

bind pmt_lookup pmt_lookup_monitor mon_u (.core_clk(core_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .lkp_req(lkp_req), .lkp_addr(lkp_addr),
  .lkp_large(lkp_large), .lkp_valid(lkp_valid), .lkp_type(lkp_type), .lkp_split(lkp_split),
  .lkp_hit(lkp_hit), .cache_no_fill(cache_no_fill), .tlb_flush(tlb_flush));
